//--- rtl/spp_fifo.sv
// Module: synchronous show-ahead byte FIFO with flush.
`timescale 1ns/1ps
module spp_fifo #(
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// FIFO side
	spp_fifo_if.mem f
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] CNT_MAX = (PW+1)'(DEPTH);

	logic [7:0] mem_r [DEPTH];
	logic [PW-1:0] wp_r;
	logic [PW-1:0] rp_r;
	logic [PW:0] cnt_r;
	logic do_push;
	logic do_pop;

	// Push into full or pop from empty is dropped
	assign do_push = f.push & !f.full;
	assign do_pop = f.pop & !f.empty;
	assign f.full = cnt_r == CNT_MAX;
	assign f.empty = cnt_r == '0;
	assign f.rdata = mem_r[rp_r];

	// Storage, no reset needed
	always_ff @(posedge pclk) begin
		if (do_push) begin
			mem_r[wp_r] <= f.wdata;
		end
	end

	// Pointers and fill count; flush beats everything
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else if (f.flush) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			if (do_push) begin
				wp_r <= (wp_r == PW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
			end
			if (do_pop) begin
				rp_r <= (rp_r == PW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
			end
			cnt_r <= cnt_r + {{PW{1'b0}}, do_push} - {{PW{1'b0}}, do_pop};
		end
	end

endmodule : spp_fifo

//--- rtl/spp_fifo_if.sv
// Interface: byte FIFO push/pop carrier between port logic and FIFO.
`timescale 1ns/1ps
interface spp_fifo_if;
	logic push;
	logic [7:0] wdata;
	logic pop;
	logic flush;
	logic [7:0] rdata;
	logic full;
	logic empty;
	modport ctl (output push, wdata, pop, flush, input rdata, full, empty);
	modport mem (input push, wdata, pop, flush, output rdata, full, empty);
endinterface : spp_fifo_if

//--- rtl/spp_pkg.sv
// Package: register map, field positions and timing of the SPI port.
package spp_pkg;

	// ********************************************************
	// Register indices (byte address is four times the index)
	// ********************************************************
	localparam logic [15:0] SPP_CFG_IDX = 16'hc0c8;
	localparam logic [15:0] SPP_CTRL_IDX = 16'hc0ca;
	localparam logic [15:0] SPP_IEN_IDX = 16'hc0cc;
	localparam logic [15:0] SPP_STAT_IDX = 16'hc0ce;
	localparam logic [15:0] SPP_ICLR_IDX = 16'hc0d0;
	localparam logic [15:0] SPP_DATA_IDX = 16'hc0d6;
	localparam int SPP_AW = 18;

	// ********************************************************
	// Field positions
	// ********************************************************
	localparam int SPP_CFG_MACT = 7;
	localparam int SPP_CFG_MEN = 6;
	localparam int SPP_CTRL_FINIT = 14;
	localparam int SPP_CTRL_BYTE = 13;
	localparam int SPP_CTRL_RDEN = 10;
	localparam int SPP_CTRL_TXRDY = 9;
	localparam int SPP_CTRL_RXRDY = 8;
	localparam int SPP_CTRL_TXEMP = 7;
	localparam int SPP_CTRL_RXFULL = 6;
	localparam int SPP_CTRL_TXLEN = 3;
	localparam int SPP_CTRL_RXLEN = 0;
	localparam int SPP_STAT_ERR = 7;
	localparam int SPP_IRQ_RX = 2;
	localparam int SPP_IRQ_TX = 1;
	localparam int SPP_IRQ_BLK = 0;

	// ********************************************************
	// Reset values
	// ********************************************************
	localparam logic [2:0] SPP_IEN_RST = 3'h0;
	localparam logic [2:0] SPP_LEN_RST = 3'h0;

	// ********************************************************
	// Timing
	// ********************************************************
	localparam int SPP_CLK_NS = 10;
	localparam int SPP_SCK_HALF_NS = 40;
	localparam int SPP_SCK_HALF_CYC = SPP_SCK_HALF_NS / SPP_CLK_NS;

	typedef enum logic {SPP_IDLE, SPP_RUN} spp_state_e;

	// Register index to APB byte address match
	function automatic logic spp_hit(input logic [SPP_AW-1:0] a,
		input logic [15:0] idx);
		return a == {idx, 2'h0};
	endfunction : spp_hit

	// Bit-length field to bit count, zero meaning a whole byte
	function automatic logic [3:0] spp_len(input logic [2:0] f);
		return (f == 3'h0) ? 4'h8 : {1'b0, f};
	endfunction : spp_len

endpackage : spp_pkg

//--- rtl/spp_spi_port.sv
// Module: SPI port status, bit-length control, interrupts and shifter.
`timescale 1ns/1ps
module spp_spi_port import spp_pkg::*; #(
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [SPP_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt request
	output logic irq,
	// SPI pins, output enables active low
	input wire logic spi_sck_i,
	output logic spi_sck_o,
	output logic spi_sck_oe_n,
	input wire logic spi_ss_n_i,
	output logic spi_ss_n_o,
	output logic spi_ss_n_oe_n,
	input wire logic spi_mosi_i,
	output logic spi_mosi_o,
	output logic spi_mosi_oe_n,
	input wire logic spi_miso_i,
	output logic spi_miso_o,
	output logic spi_miso_oe_n
);

	// ********************************************************
	// Declarations
	// ********************************************************
	spp_fifo_if txf();
	spp_fifo_if rxf();
	logic [2:0] sck_q;
	logic [2:0] ss_q;
	logic [1:0] mosi_q;
	logic [1:0] miso_q;
	logic master_en_r, byte_mode_r, rd_req_r;
	logic [2:0] txlen_r, rxlen_r, ien_r;
	logic err_r, rxf_r, txf_r, blkf_r;
	logic [31:0] prdata_r;
	logic pslverr_r;
	spp_state_e state_r;
	logic master_run_r, is_rd_r, sck_r;
	logic [7:0] tx_sh_r, rx_sh_r;
	logic [3:0] cnt_r, div_r, cur_len;
	logic wr, rd_setup, ctrl_wr, iclr_wr, finit, data_rd;
	logic tick, rise_ev, fall_ev, in_bit, ss_fall, ss_high;
	logic m_start, s_start, start, done, abort, rx_push, tx_pop;
	logic underflow, overflow, mapped;
	logic [15:0] ctrl_val, cfg_val, stat_val;

	// Both FIFOs share one depth; init flushes them together
	spp_fifo #(.DEPTH(FIFO_DEPTH)) u_spp_fifo_tx (
		.pclk(pclk), .presetn(presetn), .f(txf));
	spp_fifo #(.DEPTH(FIFO_DEPTH)) u_spp_fifo_rx (
		.pclk(pclk), .presetn(presetn), .f(rxf));

	// ********************************************************
	// Pin synchronisers
	// ********************************************************
	// Two flops before any logic; third stage only for edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_q <= 3'h0;
			ss_q <= 3'h7;
			mosi_q <= 2'h0;
			miso_q <= 2'h0;
		end else begin
			sck_q <= {sck_q[1:0], spi_sck_i};
			ss_q <= {ss_q[1:0], spi_ss_n_i};
			mosi_q <= {mosi_q[0], spi_mosi_i};
			miso_q <= {miso_q[0], spi_miso_i};
		end
	end

	// ********************************************************
	// APB decode
	// ********************************************************
	assign wr = psel & penable & pwrite;
	assign rd_setup = psel & !penable & !pwrite;
	assign ctrl_wr = wr & spp_hit(paddr, SPP_CTRL_IDX);
	assign iclr_wr = wr & spp_hit(paddr, SPP_ICLR_IDX);
	assign finit = ctrl_wr & pwdata[SPP_CTRL_FINIT];
	assign data_rd = psel & penable & !pwrite & spp_hit(paddr, SPP_DATA_IDX);
	assign txf.push = wr & spp_hit(paddr, SPP_DATA_IDX);
	assign txf.wdata = pwdata[7:0];
	assign rxf.pop = data_rd;
	assign txf.flush = finit;
	assign rxf.flush = finit;
	assign mapped = spp_hit(paddr, SPP_CFG_IDX) |
		spp_hit(paddr, SPP_CTRL_IDX) | spp_hit(paddr, SPP_IEN_IDX) |
		spp_hit(paddr, SPP_STAT_IDX) | spp_hit(paddr, SPP_ICLR_IDX) |
		spp_hit(paddr, SPP_DATA_IDX);

	// Read views; status has no write path at all
	assign cfg_val = 16'(({15'h0, master_run_r & (state_r == SPP_RUN)}
		<< SPP_CFG_MACT) | ({15'h0, master_en_r} << SPP_CFG_MEN));
	always_comb begin
		ctrl_val = 16'h0;
		ctrl_val[SPP_CTRL_BYTE] = byte_mode_r;
		ctrl_val[SPP_CTRL_RDEN] = rd_req_r;
		ctrl_val[SPP_CTRL_TXRDY] = !txf.full;
		ctrl_val[SPP_CTRL_RXRDY] = !rxf.empty;
		ctrl_val[SPP_CTRL_TXEMP] = txf.empty;
		ctrl_val[SPP_CTRL_RXFULL] = rxf.full;
		ctrl_val[SPP_CTRL_TXLEN +: 3] = txlen_r;
		ctrl_val[SPP_CTRL_RXLEN +: 3] = rxlen_r;
		stat_val = 16'h0;
		stat_val[SPP_STAT_ERR] = err_r;
		stat_val[SPP_IRQ_RX] = rxf_r;
		stat_val[SPP_IRQ_TX] = txf_r;
		stat_val[SPP_IRQ_BLK] = blkf_r;
	end

	// Read data captured in setup; write-only registers read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0;
			pslverr_r <= 1'b0;
		end else if (psel & !penable) begin
			pslverr_r <= !mapped;
			if (!rd_setup) begin
				prdata_r <= 32'h0;
			end else if (spp_hit(paddr, SPP_CFG_IDX)) begin
				prdata_r <= {16'h0, cfg_val};
			end else if (spp_hit(paddr, SPP_CTRL_IDX)) begin
				prdata_r <= {16'h0, ctrl_val};
			end else if (spp_hit(paddr, SPP_IEN_IDX)) begin
				prdata_r <= {29'h0, ien_r};
			end else if (spp_hit(paddr, SPP_STAT_IDX)) begin
				prdata_r <= {16'h0, stat_val};
			end else if (spp_hit(paddr, SPP_DATA_IDX)) begin
				prdata_r <= {24'h0, rxf.rdata};
			end else begin
				prdata_r <= 32'h0;
			end
		end
	end
	assign prdata = prdata_r;
	assign pready = 1'b1;
	assign pslverr = pslverr_r & psel & penable;

	// ********************************************************
	// Control and enable registers
	// ********************************************************
	// Mode bit frozen while master engine is active
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			master_en_r <= 1'b0;
			byte_mode_r <= 1'b0;
			txlen_r <= SPP_LEN_RST;
			rxlen_r <= SPP_LEN_RST;
			ien_r <= SPP_IEN_RST;
		end else begin
			if (wr & spp_hit(paddr, SPP_CFG_IDX) & (state_r == SPP_IDLE)) begin
				master_en_r <= pwdata[SPP_CFG_MEN];
			end
			if (ctrl_wr) begin
				byte_mode_r <= pwdata[SPP_CTRL_BYTE];
				txlen_r <= pwdata[SPP_CTRL_TXLEN +: 3];
				rxlen_r <= pwdata[SPP_CTRL_RXLEN +: 3];
			end
			if (wr & spp_hit(paddr, SPP_IEN_IDX)) begin
				ien_r <= pwdata[2:0];
			end
		end
	end

	// Read request: master start consumes it, a write wins over that
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_req_r <= 1'b0;
		end else if (ctrl_wr) begin
			rd_req_r <= pwdata[SPP_CTRL_RDEN];
		end else if (m_start & rd_req_r) begin
			rd_req_r <= 1'b0;
		end
	end

	// ********************************************************
	// Bit engine
	// ********************************************************
	assign ss_fall = ss_q[2] & !ss_q[1];
	assign ss_high = ss_q[1];
	assign tick = master_run_r & (div_r == 4'(SPP_SCK_HALF_CYC - 1));
	assign rise_ev = master_run_r ? (tick & !sck_r) : (sck_q[1] & !sck_q[2]);
	assign fall_ev = master_run_r ? (tick & sck_r) : (!sck_q[1] & sck_q[2]);
	assign in_bit = master_run_r ? miso_q[1] : mosi_q[1];
	assign cur_len = is_rd_r ? spp_len(rxlen_r) : spp_len(txlen_r);
	assign m_start = (state_r == SPP_IDLE) & master_en_r & !finit &
		(rd_req_r | !txf.empty);
	assign s_start = (state_r == SPP_IDLE) & !master_en_r & ss_fall;
	assign start = m_start | s_start;
	assign abort = (state_r == SPP_RUN) & !master_run_r & ss_high;
	// Master ends after last falling edge, slave after last rising
	// At-or-above compare: a length cut mid-frame cannot hang us
	assign done = (state_r == SPP_RUN) & (master_run_r ?
		(fall_ev & (cnt_r >= cur_len)) :
		(rise_ev & ((cnt_r + 4'h1) >= cur_len)));
	assign tx_pop = start & !rd_req_r & !txf.empty;
	assign txf.pop = tx_pop;
	assign underflow = s_start & !rd_req_r & txf.empty;
	assign rx_push = done & is_rd_r;
	assign overflow = rx_push & rxf.full;
	assign rxf.push = rx_push;
	assign rxf.wdata = master_run_r ? rx_sh_r : {rx_sh_r[6:0], in_bit};

	// Sequencer; slave direction follows the read request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= SPP_IDLE;
			master_run_r <= 1'b0;
			is_rd_r <= 1'b0;
		end else begin
			case (state_r)
				SPP_IDLE: begin
					if (start) begin
						state_r <= SPP_RUN;
						master_run_r <= m_start;
						is_rd_r <= rd_req_r;
					end
				end
				SPP_RUN: begin
					if (done | abort | finit) begin
						state_r <= SPP_IDLE;
						master_run_r <= 1'b0;
					end
				end
				default: state_r <= SPP_IDLE;
			endcase
		end
	end

	// Shift registers and bit count; data leaves MSB first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_sh_r <= 8'h0;
			rx_sh_r <= 8'h0;
			cnt_r <= 4'h0;
		end else if (start) begin
			tx_sh_r <= tx_pop ? txf.rdata : 8'h0;
			rx_sh_r <= 8'h0;
			cnt_r <= 4'h0;
		end else if (state_r == SPP_RUN) begin
			if (rise_ev) begin
				rx_sh_r <= {rx_sh_r[6:0], in_bit};
				cnt_r <= cnt_r + 4'h1;
			end
			if (fall_ev) begin
				tx_sh_r <= {tx_sh_r[6:0], 1'b0};
			end
		end
	end

	// Master clock divider: one half period per tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= 4'h0;
			sck_r <= 1'b0;
		end else if (!master_run_r | (state_r != SPP_RUN)) begin
			div_r <= 4'h0;
			sck_r <= 1'b0;
		end else if (tick) begin
			div_r <= 4'h0;
			sck_r <= !sck_r;
		end else begin
			div_r <= div_r + 4'h1;
		end
	end

	// ********************************************************
	// Status flags and interrupt
	// ********************************************************
	// Error set wins over init; only init clears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_r <= 1'b0;
		end else if (underflow | overflow) begin
			err_r <= 1'b1;
		end else if (finit) begin
			err_r <= 1'b0;
		end
	end

	// Flags record regardless of enable; set beats clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxf_r <= 1'b0;
			txf_r <= 1'b0;
			blkf_r <= 1'b0;
		end else begin
			if (rx_push & byte_mode_r) begin
				rxf_r <= 1'b1;
			end else if (data_rd) begin
				rxf_r <= 1'b0;
			end
			if (done & !is_rd_r & byte_mode_r) begin
				txf_r <= 1'b1;
			end else if (iclr_wr & pwdata[SPP_IRQ_TX]) begin
				txf_r <= 1'b0;
			end
			if (done & !byte_mode_r & txf.empty) begin
				blkf_r <= 1'b1;
			end else if (iclr_wr & pwdata[SPP_IRQ_BLK]) begin
				blkf_r <= 1'b0;
			end
		end
	end

	assign irq = |({rxf_r, txf_r, blkf_r} & ien_r);

	// ********************************************************
	// Pin drive
	// ********************************************************
	// Slave drives MISO only while selected in its write phase
	assign spi_sck_o = sck_r;
	assign spi_sck_oe_n = !master_en_r;
	assign spi_ss_n_o = !(master_run_r & (state_r == SPP_RUN));
	assign spi_ss_n_oe_n = !master_en_r;
	assign spi_mosi_o = tx_sh_r[7];
	assign spi_mosi_oe_n = !master_en_r;
	assign spi_miso_o = tx_sh_r[7];
	assign spi_miso_oe_n = !(!master_en_r & !ss_high & !rd_req_r);

	// ********************************************************
	// Assertions
	// ********************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_ctrl_read;
		rd_setup & spp_hit(paddr, SPP_CTRL_IDX);
	endsequence
	sequence s_stat_read;
		rd_setup & spp_hit(paddr, SPP_STAT_IDX);
	endsequence

	a_rdreq_self_clear: assert property (
		(m_start & rd_req_r & !ctrl_wr) |=> !rd_req_r & is_rd_r)
		else $error("read request did not clear at read start");
	a_txrdy_view: assert property (
		s_ctrl_read |=> prdata[SPP_CTRL_TXRDY] == !$past(txf.full))
		else $error("transmit ready readback wrong");
	a_rxrdy_view: assert property (
		s_ctrl_read |=> prdata[SPP_CTRL_RXRDY] == !$past(rxf.empty))
		else $error("receive ready readback wrong");
	a_txemp_full_view: assert property (
		s_ctrl_read |=> (prdata[SPP_CTRL_TXEMP] == $past(txf.empty)) &&
		(prdata[SPP_CTRL_RXFULL] == $past(rxf.full)))
		else $error("FIFO state readback wrong");
	a_len_count: assert property (
		(state_r == SPP_RUN) |-> (cnt_r <= (is_rd_r ? spp_len(rxlen_r) :
		spp_len(txlen_r))))
		else $error("bit count ran past the transfer length");
	a_irq_gate: assert property (
		(wr & spp_hit(paddr, SPP_IEN_IDX) & (pwdata[2:0] == 3'h0))
		|=> !irq)
		else $error("interrupt raised with all enables off");
	a_err_on_fault: assert property (
		(underflow | overflow) |=> err_r)
		else $error("FIFO fault did not set error flag");
	a_err_sticky: assert property (
		(err_r & !finit) |=> err_r)
		else $error("error flag cleared without FIFO init");
	a_init_clears: assert property (
		(finit & !underflow & !overflow) |=> !err_r & txf.empty & rxf.empty)
		else $error("FIFO init did not clear FIFOs and error");
	a_stat_readback: assert property (
		s_stat_read |=> prdata == {24'h0, $past(err_r), 4'h0,
		$past(rxf_r), $past(txf_r), $past(blkf_r)})
		else $error("status readback wrong");
	a_tx_clear: assert property (
		(iclr_wr & pwdata[1] & pwdata[0] & !done) |=> !txf_r & !blkf_r)
		else $error("interrupt clear did not clear flags");

endmodule : spp_spi_port

//--- testbench/spp_spi_peer.sv
// Partner model: far-side SPI device, slave or master as a test needs.
`timescale 1ns/1ps
module spp_spi_peer (
	// Resolved link wires
	input wire logic sck,
	input wire logic ss_n,
	input wire logic mosi,
	input wire logic miso,
	// Values this side puts on the wires
	output logic sck_d,
	output logic ss_n_d,
	output logic mosi_d,
	output logic miso_d
);
	logic master_on = 1'b0;
	logic junk = 1'b0;
	logic mosi_r = 1'b0;
	logic [7:0] tx_byte = 8'h00;
	logic [7:0] rx_val = 8'h00;
	int rx_cnt = 0;
	int bit_i = 7;

	// Clock and select stand still outside frames
	initial begin
		sck_d = 1'b0;
		ss_n_d = 1'b1;
	end

	// Released data lines keep moving, never hold the last bit
	always #7 junk = ~junk;
	assign mosi_d = (master_on && !ss_n_d) ? mosi_r : junk;
	assign miso_d = (!master_on && !ss_n && bit_i >= 0) ?
		tx_byte[bit_i[2:0]] : junk;

	// Slave role: capture on rising, next bit after falling
	always @(negedge ss_n) begin
		if (!master_on) begin
			rx_cnt = 0;
			rx_val = 8'h00;
			bit_i = 7;
		end
	end
	always @(posedge sck) begin
		if (!master_on && !ss_n) begin
			rx_val = {rx_val[6:0], mosi};
			rx_cnt++;
		end
	end
	always @(negedge sck) begin
		if (!master_on && !ss_n) begin
			bit_i--;
		end
	end

	// Master role: one frame, sampling late in the high phase
	task send(input logic [7:0] b, input int n);
		master_on = 1'b1;
		rx_cnt = 0;
		rx_val = 8'h00;
		#3 ss_n_d = 1'b0;
		#100;
		for (int i = 7; i > 7 - n; i--) begin
			mosi_r = b[i];
			#40 sck_d = 1'b1;
			#35 rx_val = {rx_val[6:0], miso};
			rx_cnt++;
			#5 sck_d = 1'b0;
		end
		#100 ss_n_d = 1'b1;
		#200 master_on = 1'b0;
	endtask : send
endmodule : spp_spi_peer

//--- testbench/tb_spi_port_status_and_interrupts.sv
// Testbench: SPI port flags, bit lengths and interrupt gating.
`timescale 1ns/1ps
module tb_spi_port_status_and_interrupts import spp_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, perr;
	logic [SPP_AW-1:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic sck_o, sck_oe_n, ss_n_o, ss_oe_n, mo_o, mo_oe_n, mi_o, mi_oe_n;
	logic p_sck, p_ss_n, p_mo, p_mi, sck_w, ss_n_w, mo_w, mi_w;
	logic [31:0] seed = 32'h0001_18ec;
	logic [7:0] b, pb;
	logic [7:0] q[$];
	int failures = 0;
	int total_checks = 0;
	int cyc = 0;
	int k, fld, ien_m, stat_m;

	// Each wire follows whoever holds its enable low
	assign sck_w = sck_oe_n ? p_sck : sck_o;
	assign ss_n_w = ss_oe_n ? p_ss_n : ss_n_o;
	assign mo_w = mo_oe_n ? p_mo : mo_o;
	assign mi_w = mi_oe_n ? p_mi : mi_o;

	spp_spi_port #(.FIFO_DEPTH(8)) u_spp_spi_port (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq),
		.spi_sck_i(sck_w), .spi_sck_o(sck_o), .spi_sck_oe_n(sck_oe_n),
		.spi_ss_n_i(ss_n_w), .spi_ss_n_o(ss_n_o), .spi_ss_n_oe_n(ss_oe_n),
		.spi_mosi_i(mo_w), .spi_mosi_o(mo_o), .spi_mosi_oe_n(mo_oe_n),
		.spi_miso_i(mi_w), .spi_miso_o(mi_o), .spi_miso_oe_n(mi_oe_n));

	spp_spi_peer u_spp_spi_peer (
		.sck(sck_w), .ss_n(ss_n_w), .mosi(mo_w), .miso(mi_w),
		.sck_d(p_sck), .ss_n_d(p_ss_n), .mosi_d(p_mo), .miso_d(p_mi));

	// ****************************
	// Helpers
	// ****************************
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	// Interrupt line expected from model flags and enables
	function automatic logic eirq();
		return (stat_m & ien_m & 7) != 0;
	endfunction : eirq

	task end_sim();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim

	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	// One APB transfer; request held until pready is seen
	task apb(input logic [15:0] i, input logic w, input logic [15:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {i, 2'h0};
		pwdata <= {16'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [15:0] i, input logic [15:0] d);
		apb(i, 1'b1, d);
	endtask : wr

	task rc(input logic [15:0] i, input logic [15:0] m, input logic [15:0] e);
		apb(i, 1'b0, 16'h0);
		chk(r & {16'h0, m}, {16'h0, e});
	endtask : rc

	// Bounded wait for one register bit
	task poll(input logic [15:0] i, input int p, input logic v);
		for (int n = 0; n < 400; n++) begin
			apb(i, 1'b0, 16'h0);
			if (r[p] === v) break;
		end
	endtask : poll

	task done(input string s);
		$display("test %s done at %0t", s, $time);
	endtask : done

	// Clock, and a cycle ceiling well above the expected run
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			failures++;
			end_sim();
		end
	end

	// ****************************
	// Main sequence
	// ****************************
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 18'h0;
		pwdata = 32'h0;
		stat_m = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rc(SPP_CTRL_IDX, 16'h07ff, 16'h0280);
		rc(SPP_IEN_IDX, 16'hffff, 16'h0000);
		wr(SPP_STAT_IDX, 16'hffff);
		rc(SPP_STAT_IDX, 16'hffff, 16'h0000);
		apb(16'hc0c4, 1'b0, 16'h0);
		chk({31'h0, perr}, 32'h1);
		for (k = 0; k < 4; k++) begin
			ien_m = xs() & 7;
			wr(SPP_IEN_IDX, ien_m[15:0]);
			rc(SPP_IEN_IDX, 16'hffff, ien_m[15:0]);
		end
		done("reset and registers");
		// Master: every length, write then read
		wr(SPP_CFG_IDX, 16'h0040);
		for (k = 1; k <= 8; k++) begin
			fld = k % 8;
			ien_m = (k % 2) * 6;
			wr(SPP_IEN_IDX, ien_m[15:0]);
			b = 8'(xs());
			wr(SPP_CTRL_IDX, 16'h2000 | 16'(fld << 3));
			wr(SPP_DATA_IDX, {8'h0, b});
			poll(SPP_STAT_IDX, SPP_IRQ_TX, 1'b1);
			stat_m = 2;
			chk(u_spp_spi_peer.rx_cnt, k);
			chk(u_spp_spi_peer.rx_val, b >> (8 - k));
			rc(SPP_STAT_IDX, 16'h0083, 16'h0002);
			chk(irq, eirq());
			wr(SPP_ICLR_IDX, 16'h0002);
			stat_m = 0;
			rc(SPP_STAT_IDX, 16'h0002, 16'h0000);
			wr(SPP_CTRL_IDX, 16'h6000);
			pb = 8'(xs());
			u_spp_spi_peer.tx_byte = pb;
			wr(SPP_CTRL_IDX, 16'h2400 | 16'(fld));
			poll(SPP_CTRL_IDX, SPP_CTRL_RXRDY, 1'b1);
			chk(r[SPP_CTRL_RDEN], 1'b0);
			stat_m = 4;
			rc(SPP_STAT_IDX, 16'h0004, 16'h0004);
			chk(irq, eirq());
			rc(SPP_DATA_IDX, 16'h00ff, 16'(pb >> (8 - k)));
			stat_m = 0;
			rc(SPP_CTRL_IDX, 16'h0100, 16'h0000);
		end
		done("master lengths");
		// Block-mode read request raises the block flag
		ien_m = 1;
		wr(SPP_IEN_IDX, 16'h0001);
		wr(SPP_CTRL_IDX, 16'h0400);
		poll(SPP_STAT_IDX, SPP_IRQ_BLK, 1'b1);
		stat_m = 1;
		rc(SPP_STAT_IDX, 16'h0001, 16'h0001);
		chk(irq, eirq());
		wr(SPP_ICLR_IDX, 16'h0001);
		stat_m = 0;
		rc(SPP_STAT_IDX, 16'h0001, 16'h0000);
		chk(irq, eirq());
		wr(SPP_CTRL_IDX, 16'h4000);
		rc(SPP_CTRL_IDX, 16'h43c0, 16'h0280);
		done("block flag");
		// Slave transmit: fill, send one, flush, underflow
		wr(SPP_CFG_IDX, 16'h0000);
		wr(SPP_CTRL_IDX, 16'h2000);
		q.delete();
		for (k = 0; k < 8; k++) begin
			b = 8'(xs());
			q.push_back(b);
			wr(SPP_DATA_IDX, {8'h0, b});
		end
		rc(SPP_CTRL_IDX, 16'h0280, 16'h0000);
		u_spp_spi_peer.send(8'h00, 8);
		chk(u_spp_spi_peer.rx_val, q[0]);
		rc(SPP_CTRL_IDX, 16'h0200, 16'h0200);
		wr(SPP_CTRL_IDX, 16'h6000);
		rc(SPP_CTRL_IDX, 16'h0080, 16'h0080);
		u_spp_spi_peer.send(8'h5a, 8);
		rc(SPP_STAT_IDX, 16'h0080, 16'h0080);
		rc(SPP_CTRL_IDX, 16'h0080, 16'h0080);
		done("slave transmit");
		// Slave receive past a full FIFO
		wr(SPP_CTRL_IDX, 16'h6400);
		rc(SPP_STAT_IDX, 16'h0080, 16'h0000);
		q.delete();
		for (k = 0; k < 9; k++) begin
			b = 8'(xs());
			q.push_back(b);
			u_spp_spi_peer.send(b, 8);
		end
		rc(SPP_CTRL_IDX, 16'h0140, 16'h0140);
		rc(SPP_STAT_IDX, 16'h0080, 16'h0080);
		wr(SPP_STAT_IDX, 16'h0000);
		wr(SPP_ICLR_IDX, 16'h0003);
		rc(SPP_STAT_IDX, 16'h0080, 16'h0080);
		rc(SPP_DATA_IDX, 16'h00ff, {8'h0, q[0]});
		wr(SPP_CTRL_IDX, 16'h6400);
		rc(SPP_CTRL_IDX, 16'h4140, 16'h0000);
		rc(SPP_STAT_IDX, 16'h0080, 16'h0000);
		done("slave overflow");
		end_sim();
	end
endmodule : tb_spi_port_status_and_interrupts
